// [frame_synced_pwm.sv]
// Frame-synchronised PWM generator with host register port and output selector
`timescale 1ns/10ps
`default_nettype none
`include "pwm_regs.svh"
module frame_synced_pwm
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic host_select,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire logic [3:0] host_reg_index,
  input wire logic [15:0] host_write_data,
  output logic [15:0] host_read_data,
  output logic host_transfer_ready,
  input wire logic frame_sync,
  input wire logic hard_pulse_in,
  output logic pwm_out
);

  // Maps a host index onto a storage slot; odd or unused indexes miss
  function automatic decode_type decode_index(input logic [3:0] index);
    decode_type res;
    res.hit = 1'b1;
    res.slot = `SLOT_CTRL_LOW;
    unique case (index)
      `OFF_CTRL_LOW: res.slot = `SLOT_CTRL_LOW;
      `OFF_CTRL_HIGH: res.slot = `SLOT_CTRL_HIGH;
      `OFF_PERIOD_LOW: res.slot = `SLOT_PERIOD_LOW;
      `OFF_PERIOD_HIGH: res.slot = `SLOT_PERIOD_HIGH;
      `OFF_HIGH_TIME_LOW: res.slot = `SLOT_HIGH_TIME_LOW;
      `OFF_HIGH_TIME_HIGH: res.slot = `SLOT_HIGH_TIME_HIGH;
      default: begin
        res.hit = 1'b0;
        res.slot = `SLOT_MISS; // Reads of this slot return zero
      end
    endcase
    return res;
  endfunction

  reg_bank_if rb ();

  reg_bank #(
    .DEPTH(`REG_COUNT)
  ) u_reg_bank (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bus(rb.bank)
  );

  // Host port
  logic ready_ff;
  logic nxt_ready;
  logic accept;
  decode_type dec;

  // An access is taken only while ready; the next cycle is a turnaround
  always_comb begin
    dec = decode_index(host_reg_index);
    accept = host_select && ready_ff && (host_write_strobe || host_read_strobe);
    nxt_ready = !accept;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  // Write wins if both strobes are raised; unmapped writes are dropped
  assign rb.wr_en = accept && host_write_strobe && dec.hit;
  assign rb.rd_en = accept && host_read_strobe && !host_write_strobe;
  assign rb.slot = dec.slot;
  assign rb.wr_data = host_write_data;
  assign host_transfer_ready = ready_ff;
  // Read data straight from the bank register; unmapped reads give zero there
  assign host_read_data = rb.rd_data;

  // Generator
  gen_state_type state_ff;
  gen_state_type nxt_state;
  logic sync_prev_ff;
  logic nxt_sync_prev;
  logic [31:0] period_ff;
  logic [31:0] nxt_period;
  logic [31:0] high_time_ff;
  logic [31:0] nxt_high_time;
  logic [31:0] phase_ff;
  logic [31:0] nxt_phase;
  logic gen_enable;
  logic sync_fall;
  logic gen_level;

  assign gen_enable = rb.ctrl_low[`CTRL_ENABLE_BIT];

  // Snapshots keep the running period stable while software rewrites halves
  always_comb begin
    nxt_sync_prev = frame_sync;
    sync_fall = sync_prev_ff && !frame_sync;
    nxt_state = state_ff;
    nxt_period = period_ff;
    nxt_high_time = high_time_ff;
    nxt_phase = phase_ff;
    if (!gen_enable) begin
      nxt_state = GEN_IDLE;
      nxt_phase = 32'h00000000;
    end else if (sync_fall) begin
      nxt_state = GEN_RUN;
      nxt_period = rb.period;
      nxt_high_time = rb.high_time;
      nxt_phase = 32'h00000000;
    end else begin
      unique case (state_ff)
        GEN_IDLE: nxt_phase = 32'h00000000;
        GEN_RUN: begin
          // Period spans N+1 cycles, phase 0 through N
          if (phase_ff == period_ff) begin
            nxt_phase = 32'h00000000;
          end else begin
            nxt_phase = phase_ff + 32'h00000001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= GEN_IDLE;
      sync_prev_ff <= 1'b0;
      period_ff <= 32'h00000000;
      high_time_ff <= 32'h00000000;
      phase_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      sync_prev_ff <= nxt_sync_prev;
      period_ff <= nxt_period;
      high_time_ff <= nxt_high_time;
      phase_ff <= nxt_phase;
    end
  end

  // High while phase is below the count; count above N keeps it high all period
  assign gen_level = (state_ff == GEN_RUN) && (phase_ff < high_time_ff);

  // Output selector
  logic pin_ff;
  logic nxt_pin;

  always_comb begin
    unique case (rb.ctrl_low[`CTRL_SEL_MSB:`CTRL_SEL_LSB])
      `SEL_HARD_PULSE: nxt_pin = hard_pulse_in;
      `SEL_GENERATOR: nxt_pin = gen_level;
      default: nxt_pin = 1'b1;
    endcase
  end

  // Pin idles high from reset, matching the cleared selector
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_ff <= 1'b1;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pwm_out = pin_ff;

endmodule
`default_nettype wire

// [frame_synced_pwm_test.sv]
// Self-checking bench for the frame-synced PWM block
`timescale 1ns/10ps
`default_nettype none
module frame_synced_pwm_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic frame_sync = 1'b0;
  logic hard_pulse_in = 1'b0;
  logic host_select, host_write_strobe, host_read_strobe, host_transfer_ready, pwm_out;
  logic [3:0] host_reg_index;
  logic [15:0] host_write_data, host_read_data, rd;
  logic [2:0] cs [5] = '{3'h6, 3'h6, 3'h4, 3'h1, 3'h3};
  int n_mismatch = 0;
  int n_checks = 0;
  frame_synced_pwm u_frame_synced_pwm (.sys_clk, .sys_rst, .host_select, .host_write_strobe, .host_read_strobe,
    .host_reg_index, .host_write_data, .host_read_data, .host_transfer_ready, .frame_sync, .hard_pulse_in, .pwm_out);
  host_model u_host_model (.sys_clk, .host_transfer_ready, .host_read_data, .host_select, .host_write_strobe,
    .host_read_strobe, .host_reg_index, .host_write_data);
  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_host_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e, input string what);
    u_host_model.xfer(1'b0, a, 16'h0000, rd);
    chk(e, rd, what);
  endtask
  // Program both 32-bit counts, drop the frame sync, then check eight phases
  task automatic gen(input logic [31:0] n, input logic [31:0] d);
    longint k;
    wr(4'h4, n[15:0]);
    wr(4'h6, n[31:16]);
    wr(4'h8, d[15:0]);
    wr(4'hA, d[31:16]);
    wr(4'h0, 16'h0007);
    frame_sync <= 1'b1;
    edges(1);
    frame_sync <= 1'b0;
    edges(3);
    for (k = 0; k < 8; k++) begin
      chk((k % (n + 64'd1)) < d, pwm_out, "pwm phase");
      edges(1);
    end
  endtask
  // Main sequence
  initial begin
    int i;
    edges(2);
    sys_rst <= 1'b0;
    chk(1, pwm_out, "pwm in reset");
    for (i = 0; i < 12; i += 2) rdchk(i[3:0], 16'h0000, "reset value");
    wr(4'hC, 16'hFFFF);
    rdchk(4'hC, 16'h0000, "unmapped");
    wr(4'h5, 16'hFFFF);
    rdchk(4'h5, 16'h0000, "unmapped odd");
    rdchk(4'h4, 16'h0000, "odd write dropped");
    for (i = 0; i < 12; i += 2) wr(i[3:0], 16'hA500 | i[15:0]);
    for (i = 0; i < 12; i += 2) rdchk(i[3:0], 16'hA500 | i[15:0], "readback");
    gen(32'h3, 32'h2);
    gen(32'h3, 32'h5);
    gen(32'h3, 32'h0);
    gen(32'h10000, 32'h5);
    gen(32'h3, 32'h10000);
    // Selector codes with the hard pulse flipped each time
    for (i = 0; i < 5; i++) begin
      wr(4'h0, {13'h0000, cs[i]});
      hard_pulse_in <= !i[0];
      edges(3);
      chk(cs[i][1:0] == 2'h2 ? !i[0] : !cs[i][1], pwm_out, "selector");
    end
    // Re-enable without a frame sync fall keeps the generator idle
    wr(4'h0, 16'h0007);
    edges(3);
    chk(0, pwm_out, "no frame sync");
    sys_rst <= 1'b1;
    edges(2);
    sys_rst <= 1'b0;
    rdchk(4'h4, 16'h0000, "second reset");
    chk(1, pwm_out, "pwm after reset");
    print_verdict;
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    edges(20000);
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire

// [host_model.sv]
// Host side of the register port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic host_transfer_ready,
  input wire logic [15:0] host_read_data,
  output logic host_select = 1'b0,
  output logic host_write_strobe = 1'b0,
  output logic host_read_strobe = 1'b0,
  output logic [3:0] host_reg_index = 4'h0,
  output logic [15:0] host_write_data = 16'h0000
);
  // Hold the request until ready is seen; read data lands a cycle later
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge sys_clk);
    host_select <= 1'b1;
    host_write_strobe <= wr;
    host_read_strobe <= !wr;
    host_reg_index <= idx;
    host_write_data <= wd;
    do @(posedge sys_clk); while (host_transfer_ready !== 1'b1);
    host_select <= 1'b0;
    host_write_strobe <= 1'b0;
    host_read_strobe <= 1'b0;
    host_reg_index <= ~idx; // Released lines never keep the old value
    host_write_data <= ~wd;
    @(posedge sys_clk);
    rd = host_read_data;
  endtask
endmodule
`default_nettype wire

// [pwm_pkg.sv]
// Types shared by the PWM block modules
package pwm_pkg;

  typedef logic [15:0] half_type;
  typedef logic [2:0] slot_type;

  // Result of decoding a host register index
  typedef struct packed {
    logic hit;
    slot_type slot;
  } decode_type;

  // Generator activity
  typedef enum logic {
    GEN_IDLE,
    GEN_RUN
  } gen_state_type;

endpackage

// [pwm_port_chk.sv]
// Port-level assertions for the frame-synced PWM block
`timescale 1ns/10ps
`default_nettype none
module pwm_port_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic host_select,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire logic [3:0] host_reg_index,
  input wire logic [15:0] host_write_data,
  input wire logic [15:0] host_read_data,
  input wire logic host_transfer_ready,
  input wire logic frame_sync,
  input wire logic hard_pulse_in,
  input wire logic pwm_out
);
  logic [2:0] ctrl_ff;
  logic [2:0] nxt_ctrl;
  logic take;
  assign take = host_select && host_transfer_ready && (host_write_strobe || host_read_strobe);
  // Shadow of the control field; the checker cannot see the bank itself
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (take && host_write_strobe && host_reg_index == 4'h0) begin
      nxt_ctrl = host_write_data[2:0];
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= 3'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Ready low for one cycle, then back
  sequence bounce_s;
    !host_transfer_ready ##1 host_transfer_ready;
  endsequence
  ready_bounce_a: assert property (take |=> bounce_s) else $error("ready did not bounce");
  ready_start_a: assert property ($fell(sys_rst) |-> bounce_s) else $error("ready late after reset");
  ready_fall_a: assert property ($fell(host_transfer_ready) |=> host_transfer_ready) else $error("ready stuck low");
  unmapped_zero_a: assert property (take && !host_write_strobe && (host_reg_index[0] || host_reg_index > 4'hA)
    |=> host_read_data == 16'h0000) else $error("unmapped read not zero");
  read_hold_a: assert property (!take |=> $stable(host_read_data)) else $error("read data moved");
  force_high_a: assert property ($past(ctrl_ff[1]) == 1'b0 |-> pwm_out) else $error("output not forced high");
  hard_route_a: assert property ($past(ctrl_ff[1:0]) == 2'h2 |-> pwm_out == $past(hard_pulse_in))
    else $error("hard pulse not routed");
  disabled_low_a: assert property ($past(ctrl_ff, 2) == 3'h3 && $past(ctrl_ff) == 3'h3 |-> !pwm_out)
    else $error("disabled generator not low");
endmodule
bind frame_synced_pwm pwm_port_chk u_pwm_port_chk (.sys_clk, .sys_rst, .host_select, .host_write_strobe,
  .host_read_strobe, .host_reg_index, .host_write_data, .host_read_data, .host_transfer_ready, .frame_sync,
  .hard_pulse_in, .pwm_out);
`default_nettype wire

// [pwm_regs.svh]
// Register offsets, field positions, reset values and sizes of the PWM block
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// Register offsets on the 4-bit host index
`define OFF_CTRL_LOW 4'h0
`define OFF_CTRL_HIGH 4'h2
`define OFF_PERIOD_LOW 4'h4
`define OFF_PERIOD_HIGH 4'h6
`define OFF_HIGH_TIME_LOW 4'h8
`define OFF_HIGH_TIME_HIGH 4'hA

// Storage slots inside the register bank
`define SLOT_CTRL_LOW 3'h0
`define SLOT_CTRL_HIGH 3'h1
`define SLOT_PERIOD_LOW 3'h2
`define SLOT_PERIOD_HIGH 3'h3
`define SLOT_HIGH_TIME_LOW 3'h4
`define SLOT_HIGH_TIME_HIGH 3'h5
// Slot code for an unmapped index; the bank answers it with zero
`define SLOT_MISS 3'h7
`define REG_COUNT 6

// Control field positions and encodings
`define CTRL_ENABLE_BIT 2
`define CTRL_SEL_MSB 1
`define CTRL_SEL_LSB 0
`define SEL_HARD_PULSE 2'h2
`define SEL_GENERATOR 2'h3

// Reset value of every register half
`define REG_RESET 16'h0000

`endif

// [reg_bank.sv]
// Six 16-bit register halves with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "pwm_regs.svh"
module reg_bank
  import pwm_pkg::*;
#(
  parameter int DEPTH = `REG_COUNT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  reg_bank_if.bank bus
);

  half_type mem_ff [DEPTH];
  half_type nxt_mem [DEPTH];
  half_type rd_ff;
  half_type nxt_rd;

  // Write and read next values; slots past the bank read as zero
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    nxt_rd = rd_ff;
    if (bus.wr_en) begin
      nxt_mem[bus.slot] = bus.wr_data;
    end
    if (bus.rd_en) begin
      if (int'(bus.slot) < DEPTH) begin
        nxt_rd = mem_ff[bus.slot];
      end else begin
        nxt_rd = `REG_RESET;
      end
    end
  end

  // All halves clear on reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= `REG_RESET;
      end
      rd_ff <= `REG_RESET;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff <= nxt_rd;
    end
  end

  assign bus.rd_data = rd_ff;
  assign bus.ctrl_low = mem_ff[`SLOT_CTRL_LOW];
  assign bus.period = {mem_ff[`SLOT_PERIOD_HIGH], mem_ff[`SLOT_PERIOD_LOW]};
  assign bus.high_time = {mem_ff[`SLOT_HIGH_TIME_HIGH], mem_ff[`SLOT_HIGH_TIME_LOW]};

endmodule
`default_nettype wire

// [reg_bank_if.sv]
// Link between the host port logic and the register bank
`timescale 1ns/10ps
`default_nettype none
interface reg_bank_if;
  import pwm_pkg::*;
  logic wr_en;
  logic rd_en;
  slot_type slot;
  half_type wr_data;
  half_type rd_data;
  half_type ctrl_low;
  logic [31:0] period;
  logic [31:0] high_time;

  modport port (output wr_en, output rd_en, output slot, output wr_data,
                input rd_data, input ctrl_low, input period, input high_time);
  modport bank (input wr_en, input rd_en, input slot, input wr_data,
                output rd_data, output ctrl_low, output period, output high_time);
endinterface
`default_nettype wire
